// ---- src/spm_regs.svh ----
// offsets, field positions, reset values and constants of the split and pm register slice
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

`define SPM_OFS_UP_SPLIT        8'h88
`define SPM_OFS_DN_SPLIT        8'h8c
`define SPM_OFS_PM_CAP          8'h90

`define SPM_CAP_LSB             0
`define SPM_LIMIT_LSB           16
`define SPM_BUF_ADQ             16'h0010
`define SPM_LIMIT_RST           16'h0010
`define SPM_LIMIT_UNBOUNDED     16'hffff

`define SPM_PM_ID_VAL           8'h01
`define SPM_PM_NEXT_VAL         8'ha8
`define SPM_PM_VER_VAL          3'b011
`define SPM_PM_CLK_VAL          1'b0
`define SPM_PM_RSVD20_VAL       1'b0
`define SPM_PM_DSI_VAL          1'b0
`define SPM_PM_AUX_VAL          3'b001
`define SPM_PM_D1_VAL           1'b0
`define SPM_PM_D2_VAL           1'b0
`define SPM_PM_EVT_VAL          5'b11001

`endif

// ---- src/spm_pkg.sv ----
// types shared by the split and pm register slice
package spm_pkg;
  typedef logic [15:0] spm_adq_t;
  typedef logic [16:0] spm_cnt_t;
  typedef logic [7:0]  spm_ofs_t;
endpackage

// ---- src/spm_commit_track.sv ----
// outstanding split commitment tracker for one direction
`timescale 1ns/1ps
`default_nettype none
`include "spm_regs.svh"
module spm_commit_track #(
  parameter int CW = 17
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire spm_pkg::spm_adq_t limit,
  input  wire spm_pkg::spm_adq_t req_size,
  input  wire logic           take,
  input  wire logic           cpl_valid,
  input  wire spm_pkg::spm_adq_t cpl_size,
  output logic                room_ok,
  output logic [CW-1:0]       outstanding_q
);
  logic [CW-1:0] sum;
  logic [CW-1:0] nxt;

  // all ones means forward regardless of free completion space
  assign sum     = outstanding_q + CW'(req_size);
  assign room_ok = (limit == `SPM_LIMIT_UNBOUNDED) || (sum <= CW'(limit));

  // completions retire space; saturate at zero to survive stray returns
  always_comb begin
    nxt = outstanding_q;
    if (take) begin
      nxt = sum;
    end
    if (cpl_valid) begin
      nxt = (nxt > CW'(cpl_size)) ? nxt - CW'(cpl_size) : '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outstanding_q <= '0;
    end else begin
      outstanding_q <= nxt;
    end
  end
endmodule
`default_nettype wire

// ---- src/spm_split_pm_regs.sv ----
// split transaction budget and pm capability configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "spm_regs.svh"
module spm_split_pm_regs (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire spm_pkg::spm_ofs_t cfg_addr,
  input  wire logic [3:0]        cfg_be,
  input  wire logic [31:0]       cfg_wdata,
  output logic [31:0]            cfg_rdata_q,
  output logic                   cfg_rvalid_q,
  input  wire logic              up_req_valid,
  input  wire spm_pkg::spm_adq_t up_req_size,
  input  wire logic              up_cpl_valid,
  input  wire spm_pkg::spm_adq_t up_cpl_size,
  output logic                   up_fwd_q,
  input  wire logic              dn_req_valid,
  input  wire spm_pkg::spm_adq_t dn_req_size,
  input  wire logic              dn_cpl_valid,
  input  wire spm_pkg::spm_adq_t dn_cpl_size,
  output logic                   dn_fwd_q,
  output logic                   split_req_delayed_q,
  input  wire logic              split_req_delayed_clr
);
  logic              rst_meta_q;
  logic              rst_n;
  spm_pkg::spm_adq_t up_limit_q;
  spm_pkg::spm_adq_t dn_limit_q;
  logic              up_ok;
  logic              dn_ok;
  logic              up_take;
  logic              dn_take;
  logic [31:0]       rd_mux;
  logic [31:0]       pm_word;
  logic [16:0]       up_outst;
  logic [16:0]       dn_outst;

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // no full half-word write needed: a single byte lane updates only its byte
  function automatic spm_pkg::spm_adq_t merge_hi(input spm_pkg::spm_adq_t old,
                                                 input logic [3:0] be,
                                                 input logic [31:0] wd);
    spm_pkg::spm_adq_t v;
    v = old;
    if (be[2]) begin
      v[7:0] = wd[23:16];
    end
    if (be[3]) begin
      v[15:8] = wd[31:24];
    end
    return v;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_limit_q <= `SPM_LIMIT_RST;
    end else if (cfg_wr && cfg_addr == `SPM_OFS_UP_SPLIT) begin
      up_limit_q <= merge_hi(up_limit_q, cfg_be, cfg_wdata);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dn_limit_q <= `SPM_LIMIT_RST;
    end else if (cfg_wr && cfg_addr == `SPM_OFS_DN_SPLIT) begin
      dn_limit_q <= merge_hi(dn_limit_q, cfg_be, cfg_wdata);
    end
  end

  // pm capability word built from constants only
  assign pm_word = {`SPM_PM_EVT_VAL, `SPM_PM_D2_VAL, `SPM_PM_D1_VAL, `SPM_PM_AUX_VAL,
                    `SPM_PM_DSI_VAL, `SPM_PM_RSVD20_VAL, `SPM_PM_CLK_VAL,
                    `SPM_PM_VER_VAL, `SPM_PM_NEXT_VAL, `SPM_PM_ID_VAL};

  // read-only fields have no storage, so writes cannot reach them
  always_comb begin
    case (cfg_addr)
      `SPM_OFS_UP_SPLIT: rd_mux = {up_limit_q, `SPM_BUF_ADQ};
      `SPM_OFS_DN_SPLIT: rd_mux = {dn_limit_q, `SPM_BUF_ADQ};
      `SPM_OFS_PM_CAP:   rd_mux = pm_word;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_q  <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata_q <= rd_mux;
      end
    end
  end

  // requester holds valid until the grant pulse; block re-take in that cycle
  assign up_take = up_req_valid && up_ok && !up_fwd_q;
  assign dn_take = dn_req_valid && dn_ok && !dn_fwd_q;

  spm_commit_track #(.CW(17)) u_up_track (
    .clk           (clk_sys),
    .rst_n         (rst_n),
    .limit         (up_limit_q),
    .req_size      (up_req_size),
    .take          (up_take),
    .cpl_valid     (up_cpl_valid),
    .cpl_size      (up_cpl_size),
    .room_ok       (up_ok),
    .outstanding_q (up_outst)
  );

  spm_commit_track #(.CW(17)) u_dn_track (
    .clk           (clk_sys),
    .rst_n         (rst_n),
    .limit         (dn_limit_q),
    .req_size      (dn_req_size),
    .take          (dn_take),
    .cpl_valid     (dn_cpl_valid),
    .cpl_size      (dn_cpl_size),
    .room_ok       (dn_ok),
    .outstanding_q (dn_outst)
  );

  // grant pulses, unbounded limit always passes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_fwd_q <= 1'b0;
      dn_fwd_q <= 1'b0;
    end else begin
      up_fwd_q <= up_take;
      dn_fwd_q <= dn_take;
    end
  end

  // sticky delayed flag; a new hold wins over a clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      split_req_delayed_q <= 1'b0;
    end else if (dn_req_valid && !dn_ok && !dn_fwd_q) begin
      split_req_delayed_q <= 1'b1;
    end else if (split_req_delayed_clr) begin
      split_req_delayed_q <= 1'b0;
    end
  end

  chk_up_cap_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_UP_SPLIT |=> cfg_rdata_q[15:0] == 16'h0010)
    else $error("upstream buffer size wrong");

  chk_dn_cap_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_DN_SPLIT |=> cfg_rdata_q[15:0] == 16'h0010)
    else $error("downstream buffer size wrong");

  chk_up_limit_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_wr && cfg_addr == `SPM_OFS_UP_SPLIT && cfg_be[3:2] == 2'b11
    |=> up_limit_q == $past(cfg_wdata[31:16]))
    else $error("upstream limit not written");

  chk_dn_limit_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_wr && cfg_addr == `SPM_OFS_DN_SPLIT && cfg_be[3:2] == 2'b11
    |=> dn_limit_q == $past(cfg_wdata[31:16]))
    else $error("downstream limit not written");

  chk_limit_reset: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> up_limit_q == 16'h0010 && dn_limit_q == 16'h0010)
    else $error("limits not reset to buffer size");

  chk_unbounded_fwd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dn_limit_q == 16'hffff && dn_req_valid && !dn_fwd_q |=> dn_fwd_q)
    else $error("unbounded limit did not forward");

  chk_held_delayed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dn_req_valid && !dn_ok && !dn_fwd_q |=> !dn_fwd_q && split_req_delayed_q)
    else $error("over-limit request not held");

  chk_pm_id_ptr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_PM_CAP |=> cfg_rdata_q[7:0] == 8'h01)
    else $error("pm id wrong");

  chk_pm_next_ptr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_PM_CAP |=> cfg_rdata_q[15:8] == 8'ha8)
    else $error("next pointer wrong");

  chk_pm_version: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_PM_CAP |=> cfg_rdata_q[18:16] == 3'b011)
    else $error("pm version wrong");

  chk_pm_clk_dsi: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_PM_CAP |=> !cfg_rdata_q[19] && !cfg_rdata_q[21])
    else $error("pm clock or dsi bit set");

  chk_pm_d1_d2: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_PM_CAP |=> cfg_rdata_q[26:25] == 2'b00)
    else $error("d1 or d2 advertised");

  chk_pm_events: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_PM_CAP |=> cfg_rdata_q[31:27] == 5'b11001)
    else $error("event support wrong");

  chk_ro_low_half: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_wr && cfg_addr == `SPM_OFS_UP_SPLIT && cfg_be[3:2] == 2'b00
    |=> $stable(up_limit_q))
    else $error("low-lane write changed limit");

  // the next four checks work from the counters, not from the room flag
  chk_dn_empty_fwd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dn_req_valid && !dn_fwd_q && dn_outst == 17'h0_0000 && dn_req_size <= dn_limit_q
    |=> dn_fwd_q)
    else $error("fitting downstream request not forwarded");

  chk_up_empty_fwd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    up_req_valid && !up_fwd_q && up_outst == 17'h0_0000 && up_req_size <= up_limit_q
    |=> up_fwd_q)
    else $error("fitting upstream request not forwarded");

  chk_dn_over_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dn_req_valid && !dn_fwd_q && dn_limit_q != 16'hffff
    && dn_outst + 17'(dn_req_size) > 17'(dn_limit_q)
    |=> !dn_fwd_q && split_req_delayed_q)
    else $error("over-limit downstream request forwarded");

  chk_up_over_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    up_req_valid && !up_fwd_q && up_limit_q != 16'hffff
    && up_outst + 17'(up_req_size) > 17'(up_limit_q)
    |=> !up_fwd_q)
    else $error("over-limit upstream request forwarded");

  chk_up_unbounded: assert property (@(posedge clk_sys) disable iff (!rst_n)
    up_limit_q == 16'hffff && up_req_valid && !up_fwd_q |=> up_fwd_q)
    else $error("unbounded upstream limit did not forward");

  chk_dn_lo_lane: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_wr && cfg_addr == `SPM_OFS_DN_SPLIT && !cfg_be[2]
    |=> dn_limit_q[7:0] == $past(dn_limit_q[7:0]))
    else $error("disabled lane changed limit low byte");

  chk_dn_hi_lane: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_wr && cfg_addr == `SPM_OFS_DN_SPLIT && !cfg_be[3]
    |=> dn_limit_q[15:8] == $past(dn_limit_q[15:8]))
    else $error("disabled lane changed limit high byte");

  chk_pm_wr_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_wr && cfg_addr == `SPM_OFS_PM_CAP |=> $stable(up_limit_q) && $stable(dn_limit_q))
    else $error("pm header write reached a limit");

  chk_rd_no_effect: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && !cfg_wr |=> $stable(up_limit_q) && $stable(dn_limit_q))
    else $error("read changed a limit");

  chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    split_req_delayed_q && !split_req_delayed_clr |=> split_req_delayed_q)
    else $error("delayed flag dropped without clear");

  chk_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    split_req_delayed_clr && !dn_req_valid |=> !split_req_delayed_q)
    else $error("delayed flag not cleared");

  chk_dn_fwd_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dn_fwd_q |-> $past(dn_req_valid))
    else $error("downstream forward without request");

  chk_up_fwd_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    up_fwd_q |-> $past(up_req_valid))
    else $error("upstream forward without request");

  cov_dn_fwd: cover property (@(posedge clk_sys) disable iff (!rst_n) dn_fwd_q);
  cov_up_fwd: cover property (@(posedge clk_sys) disable iff (!rst_n) up_fwd_q);
  cov_delayed: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(split_req_delayed_q));
  cov_pm_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_rd && cfg_addr == `SPM_OFS_PM_CAP);
  cov_flag_clr: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(split_req_delayed_q));
endmodule
`default_nettype wire

// ---- testbench/spm_split_pm_regs_test.sv ----
// self-checking bench for the split budget and pm capability registers
`timescale 1ns/1ps
`default_nettype none
module spm_split_pm_regs_test;
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic              cfg_wr = 1'b0;
  logic              cfg_rd = 1'b0;
  spm_pkg::spm_ofs_t cfg_addr = 8'h00;
  logic [3:0]        cfg_be = 4'h0;
  logic [31:0]       cfg_wdata = 32'h0000_0000;
  logic [31:0]       cfg_rdata_q;
  logic              cfg_rvalid_q;
  logic              up_req_valid = 1'b0;
  spm_pkg::spm_adq_t up_req_size = 16'h0000;
  logic              up_cpl_valid = 1'b0;
  spm_pkg::spm_adq_t up_cpl_size = 16'h0000;
  logic              up_fwd_q;
  logic              dn_req_valid = 1'b0;
  spm_pkg::spm_adq_t dn_req_size = 16'h0000;
  logic              dn_cpl_valid = 1'b0;
  spm_pkg::spm_adq_t dn_cpl_size = 16'h0000;
  logic              dn_fwd_q;
  logic              split_req_delayed_q;
  logic              split_req_delayed_clr = 1'b0;
  int                mismatches = 0;
  int                checks_done = 0;
  // pm header built field by field, id in the low byte
  localparam logic [31:0] PM_EXP = {5'b11001, 2'b00, 3'b001, 3'b000, 3'b011, 8'ha8, 8'h01};

  always #50 clk_sys = ~clk_sys;

  spm_split_pm_regs uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
    .up_req_valid(up_req_valid), .up_req_size(up_req_size),
    .up_cpl_valid(up_cpl_valid), .up_cpl_size(up_cpl_size), .up_fwd_q(up_fwd_q),
    .dn_req_valid(dn_req_valid), .dn_req_size(dn_req_size),
    .dn_cpl_valid(dn_cpl_valid), .dn_cpl_size(dn_cpl_size), .dn_fwd_q(dn_fwd_q),
    .split_req_delayed_q(split_req_delayed_q),
    .split_req_delayed_clr(split_req_delayed_clr)
  );

  // compare one observed value, count it, report a miss
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one-cycle write strobe, effective at the taking edge
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask

  // read answer lands at the same edge that takes the strobe
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk_sys);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clk_sys);
    cfg_rd = 1'b0;
    check("rvalid", {31'h0, cfg_rvalid_q}, 32'h1);
    check("rdata", cfg_rdata_q, exp);
  endtask

  task automatic drive(input logic dn, input spm_pkg::spm_adq_t sz);
    @(negedge clk_sys);
    if (dn) begin
      dn_req_valid = 1'b1;
      dn_req_size = sz;
    end else begin
      up_req_valid = 1'b1;
      up_req_size = sz;
    end
  endtask

  // watch for the forward pulse; requester drops valid once it is seen
  task automatic wait_fwd(input logic dn, input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 4 && !seen; i++) begin
      @(negedge clk_sys);
      up_cpl_valid = 1'b0;
      dn_cpl_valid = 1'b0;
      if ((dn ? dn_fwd_q : up_fwd_q) === 1'b1) begin
        seen = 1'b1;
        dn_req_valid = dn ? 1'b0 : dn_req_valid;
        up_req_valid = dn ? up_req_valid : 1'b0;
      end
    end
    check(dn ? "dn_fwd" : "up_fwd", {31'h0, seen}, {31'h0, exp});
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    cfg_read(8'h88, 32'h0010_0010);
    cfg_read(8'h8c, 32'h0010_0010);
    cfg_read(8'h90, PM_EXP);
    // read-only places must shrug off writes, limit lanes must take them
    cfg_write(8'h90, 4'hf, ~PM_EXP);
    cfg_read(8'h90, PM_EXP);
    cfg_write(8'h88, 4'h3, 32'hffff_ffff);
    cfg_read(8'h88, 32'h0010_0010);
    cfg_write(8'h8c, 4'h4, 32'h0020_ffff);
    cfg_read(8'h8c, 32'h0020_0010);
    cfg_write(8'h8c, 4'h8, 32'h0100_0000);
    cfg_read(8'h8c, 32'h0120_0010);
    cfg_read(8'h84, 32'h0000_0000);
    // downstream: exact fit passes, one more is held and flagged
    cfg_write(8'h8c, 4'hc, 32'h0010_0000);
    drive(1'b1, 16'h0010);
    wait_fwd(1'b1, 1'b1);
    drive(1'b1, 16'h0001);
    wait_fwd(1'b1, 1'b0);
    check("delayed", {31'h0, split_req_delayed_q}, 32'h1);
    @(negedge clk_sys);
    dn_cpl_valid = 1'b1;
    dn_cpl_size = 16'h0010;
    wait_fwd(1'b1, 1'b1);
    @(negedge clk_sys);
    split_req_delayed_clr = 1'b1;
    @(negedge clk_sys);
    split_req_delayed_clr = 1'b0;
    check("delayed_clr", {31'h0, split_req_delayed_q}, 32'h0);
    // upstream: over limit is held without the downstream flag
    drive(1'b0, 16'h0011);
    wait_fwd(1'b0, 1'b0);
    check("up_no_flag", {31'h0, split_req_delayed_q}, 32'h0);
    @(negedge clk_sys);
    up_req_valid = 1'b0;
    // all-ones limit forwards anything in both directions
    cfg_write(8'h88, 4'hc, 32'hffff_0000);
    cfg_write(8'h8c, 4'hc, 32'hffff_0000);
    drive(1'b0, 16'h8000);
    wait_fwd(1'b0, 1'b1);
    drive(1'b0, 16'hffff);
    wait_fwd(1'b0, 1'b1);
    drive(1'b1, 16'hffff);
    wait_fwd(1'b1, 1'b1);
    check("dn_no_flag", {31'h0, split_req_delayed_q}, 32'h0);
    cfg_read(8'h88, 32'hffff_0010);
    final_report();
  end

  // the sequence needs well under a hundred cycles; this bounds a hang
  initial begin
    #(3000 * 100);
    mismatches++;
    final_report();
  end
endmodule
`default_nettype wire
